// File: common/pdma_map.svh
`ifndef PDMA_MAP_SVH
`define PDMA_MAP_SVH
`define PDMA_ADDR_W       12
`define PDMA_DATA_W       32
`define PDMA_CNT_W        16
`define PDMA_OFS_RX_PTR   12'h100
`define PDMA_OFS_RX_CNT   12'h104
`define PDMA_OFS_TX_PTR   12'h108
`define PDMA_OFS_TX_CNT   12'h10C
`define PDMA_OFS_RX_NPTR  12'h110
`define PDMA_OFS_RX_NCNT  12'h114
`define PDMA_OFS_TX_NPTR  12'h118
`define PDMA_OFS_TX_NCNT  12'h11C
`define PDMA_OFS_CTRL     12'h120
`define PDMA_OFS_STAT     12'h124
`define PDMA_BIT_RX_EN    0
`define PDMA_BIT_RX_DIS   1
`define PDMA_BIT_TX_EN    8
`define PDMA_BIT_TX_DIS   9
`define PDMA_PTR_RST      32'h0
`define PDMA_CNT_RST      16'h0
`define PDMA_CNT_ONE      16'h1
`define PDMA_STEP_BYTE    32'h1
`define PDMA_STEP_HALF    32'h2
`define PDMA_STEP_WORD    32'h4
`define PDMA_RESP_OKAY    2'h0
`define PDMA_RESP_SLVERR  2'h2
`endif

// File: common/pdma_pkg.sv
package pdma_pkg;
  typedef enum logic [1:0] {PDMA_SZ_BYTE = 2'b00, PDMA_SZ_HALF = 2'b01, PDMA_SZ_WORD = 2'b10} pdma_size_type;
  typedef enum logic [1:0] {CH_IDLE = 2'b00, CH_WAIT = 2'b01, CH_HOLD = 2'b10} pdma_chan_state_type;
  typedef enum logic [1:0] {MEM_IDLE = 2'b00, MEM_BUS = 2'b01, MEM_DONE = 2'b10} pdma_mem_state_type;
endpackage

// File: common/pdma_chan_if.sv
`timescale 1ns/10ps
`include "pdma_map.svh"
interface pdma_chan_if;
  logic                   wrPtr;
  logic                   wrCnt;
  logic                   wrNptr;
  logic                   wrNcnt;
  logic [31:0]            wdata;
  logic                   enable;
  logic                   done;
  logic                   req;
  logic [31:0]            curPtr;
  logic [31:0]            nextPtr;
  logic [`PDMA_CNT_W-1:0] curCnt;
  logic [`PDMA_CNT_W-1:0] nextCnt;
  logic                   endFlag;
  logic                   bothFlag;
  modport chan (input wrPtr, wrCnt, wrNptr, wrNcnt, wdata, enable, done,
                output req, curPtr, nextPtr, curCnt, nextCnt, endFlag, bothFlag);
  modport ctrl (output wrPtr, wrCnt, wrNptr, wrNcnt, wdata, enable, done,
                input req, curPtr, nextPtr, curCnt, nextCnt, endFlag, bothFlag);
endinterface

// File: verilog/pdma_arb.sv
`timescale 1ns/10ps
module pdma_arb (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic reqRx,
  input  wire logic reqTx,
  input  wire logic busy,
  output logic      grantRx,
  output logic      grantTx
);
  logic grantRx_q;
  logic grantRx_d;
  logic grantTx_q;
  logic grantTx_d;

  // receive side served first
  always_comb begin
    grantRx_d = 1'b0;
    grantTx_d = 1'b0;
    if (!busy && !grantRx_q && !grantTx_q) begin
      grantRx_d = reqRx;
      grantTx_d = reqTx && !reqRx;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      grantRx_q <= 1'b0;
      grantTx_q <= 1'b0;
    end else begin
      grantRx_q <= grantRx_d;
      grantTx_q <= grantTx_d;
    end
  end

  assign grantRx = grantRx_q;
  assign grantTx = grantTx_q;
endmodule

// File: verilog/pdma_chan.sv
`timescale 1ns/10ps
`include "pdma_map.svh"
module pdma_chan #(
  parameter int CNT_W = `PDMA_CNT_W
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire logic                    trigger,
  input  wire pdma_pkg::pdma_size_type xferSize,
  pdma_chan_if.chan                    ch
);
  import pdma_pkg::*;
  logic [31:0]         curPtr_q, curPtr_d, nextPtr_q, nextPtr_d, step;
  logic [CNT_W-1:0]    curCnt_q, curCnt_d, nextCnt_q, nextCnt_d;
  logic                endFlag_q, endFlag_d, bothFlag_q, bothFlag_d, reachZero;
  pdma_chan_state_type state_q, state_d;

  always_comb begin
    case (xferSize)
      PDMA_SZ_HALF: step = `PDMA_STEP_HALF;
      PDMA_SZ_WORD: step = `PDMA_STEP_WORD;
      default:      step = `PDMA_STEP_BYTE;
    endcase
  end

  always_comb begin
    curPtr_d   = curPtr_q;
    curCnt_d   = curCnt_q;
    nextPtr_d  = nextPtr_q;
    nextCnt_d  = nextCnt_q;
    endFlag_d  = endFlag_q;
    state_d    = state_q;
    reachZero  = 1'b0;
    case (state_q)
      CH_IDLE: if (ch.enable && trigger && curCnt_q != '0) state_d = CH_WAIT;
      CH_WAIT: if (ch.done) state_d = CH_HOLD;
      CH_HOLD: state_d = CH_IDLE;
      default: state_d = CH_IDLE;
    endcase
    if (ch.done) begin
      curPtr_d  = curPtr_q + step;
      curCnt_d  = curCnt_q - 1'b1;
      reachZero = (curCnt_q == CNT_W'(`PDMA_CNT_ONE));
    end
    if (curCnt_d == '0 && nextCnt_q != '0) begin
      curPtr_d  = nextPtr_q;
      curCnt_d  = nextCnt_q;
      nextCnt_d = '0;
    end
    if (ch.wrPtr) curPtr_d = ch.wdata;
    if (ch.wrCnt) curCnt_d = ch.wdata[CNT_W-1:0];
    if (ch.wrNptr) nextPtr_d = ch.wdata;
    if (ch.wrNcnt) nextCnt_d = ch.wdata[CNT_W-1:0];
    if (ch.wrCnt || ch.wrNcnt) endFlag_d = 1'b0;
    if (reachZero) endFlag_d = 1'b1;
    bothFlag_d = (curCnt_d == '0) && (nextCnt_d == '0);
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      curPtr_q   <= `PDMA_PTR_RST;
      curCnt_q   <= CNT_W'(`PDMA_CNT_RST);
      nextPtr_q  <= `PDMA_PTR_RST;
      nextCnt_q  <= CNT_W'(`PDMA_CNT_RST);
      endFlag_q  <= 1'b0;
      bothFlag_q <= 1'b0;
      state_q    <= CH_IDLE;
    end else begin
      curPtr_q   <= curPtr_d;
      curCnt_q   <= curCnt_d;
      nextPtr_q  <= nextPtr_d;
      nextCnt_q  <= nextCnt_d;
      endFlag_q  <= endFlag_d;
      bothFlag_q <= bothFlag_d;
      state_q    <= state_d;
    end
  end

  assign ch.req      = (state_q == CH_WAIT);
  assign ch.curPtr   = curPtr_q;
  assign ch.curCnt   = curCnt_q;
  assign ch.nextPtr  = nextPtr_q;
  assign ch.nextCnt  = nextCnt_q;
  assign ch.endFlag  = endFlag_q;
  assign ch.bothFlag = bothFlag_q;
endmodule

// File: verilog/pdma_top.sv
`timescale 1ns/10ps
`include "pdma_map.svh"
module pdma_top (
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  input  wire logic [`PDMA_ADDR_W-1:0] awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [`PDMA_ADDR_W-1:0] araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire pdma_pkg::pdma_size_type xferSize,
  input  wire logic                    rxReady,
  input  wire logic [31:0]             rxData,
  output logic                         rxTake,
  input  wire logic                    txReady,
  output logic [31:0]                  txData,
  output logic                         txLoad,
  output logic                         memReq,
  output logic                         memWe,
  output logic [31:0]                  memAddr,
  output pdma_pkg::pdma_size_type      memSize,
  output logic [31:0]                  memWdata,
  input  wire logic [31:0]             memRdata,
  input  wire logic                    memAck,
  output logic                         rxBufferEnd,
  output logic                         rxBothBuffersFull,
  output logic                         txBufferEnd,
  output logic                         txBothBuffersEmpty
);
  import pdma_pkg::*;

  pdma_chan_if rxIf ();
  pdma_chan_if txIf ();

  logic                    awready_q, awready_d, awHeld_q, awHeld_d;
  logic                    wready_q, wready_d, wHeld_q, wHeld_d;
  logic [`PDMA_ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [31:0]             wData_q, wData_d;
  logic [3:0]              wStrb_q, wStrb_d;
  logic                    bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]              bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]             rdata_q, rdata_d;
  logic                    rxEn_q, rxEn_d, txEn_q, txEn_d;
  logic                    doWrite, ctrlWrite, oldErr;
  logic [31:0]             wMask, oldVal, wMerged;
  logic [32:0]             rdRes;

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  function automatic logic [32:0] regRead(input logic [`PDMA_ADDR_W-1:0] a);
    logic [32:0] r;
    r = 33'h0;
    case (a)
      `PDMA_OFS_RX_PTR:  r[31:0] = rxIf.curPtr;
      `PDMA_OFS_RX_CNT:  r[`PDMA_CNT_W-1:0] = rxIf.curCnt;
      `PDMA_OFS_TX_PTR:  r[31:0] = txIf.curPtr;
      `PDMA_OFS_TX_CNT:  r[`PDMA_CNT_W-1:0] = txIf.curCnt;
      `PDMA_OFS_RX_NPTR: r[31:0] = rxIf.nextPtr;
      `PDMA_OFS_RX_NCNT: r[`PDMA_CNT_W-1:0] = rxIf.nextCnt;
      `PDMA_OFS_TX_NPTR: r[31:0] = txIf.nextPtr;
      `PDMA_OFS_TX_NCNT: r[`PDMA_CNT_W-1:0] = txIf.nextCnt;
      `PDMA_OFS_CTRL:    r[31:0] = 32'h0;
      `PDMA_OFS_STAT: begin
        r[`PDMA_BIT_RX_EN] = rxEn_q;
        r[`PDMA_BIT_TX_EN] = txEn_q;
      end
      default:           r[32] = 1'b1;
    endcase
    return r;
  endfunction

  // always_comb so the mux follows the live registers, not only the address
  always_comb rdRes = regRead(araddr);

  // ------------------------------------------------------------
  // write data merge by byte strobes
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wMask[8*i +: 8] = {8{wStrb_q[i]}};
    end
    {oldErr, oldVal} = regRead(awAddr_q);
    wMerged          = (oldVal & ~wMask) | (wData_q & wMask);
  end

  assign doWrite      = awHeld_q && wHeld_q && !bvalid_q;
  assign ctrlWrite    = doWrite && (awAddr_q == `PDMA_OFS_CTRL);
  assign rxIf.wrPtr   = doWrite && (awAddr_q == `PDMA_OFS_RX_PTR);
  assign rxIf.wrCnt   = doWrite && (awAddr_q == `PDMA_OFS_RX_CNT);
  assign rxIf.wrNptr  = doWrite && (awAddr_q == `PDMA_OFS_RX_NPTR);
  assign rxIf.wrNcnt  = doWrite && (awAddr_q == `PDMA_OFS_RX_NCNT);
  assign txIf.wrPtr   = doWrite && (awAddr_q == `PDMA_OFS_TX_PTR);
  assign txIf.wrCnt   = doWrite && (awAddr_q == `PDMA_OFS_TX_CNT);
  assign txIf.wrNptr  = doWrite && (awAddr_q == `PDMA_OFS_TX_NPTR);
  assign txIf.wrNcnt  = doWrite && (awAddr_q == `PDMA_OFS_TX_NCNT);
  assign rxIf.wdata   = wMerged;
  assign txIf.wdata   = wMerged;
  assign rxIf.enable  = rxEn_q;
  assign txIf.enable  = txEn_q;

  // ------------------------------------------------------------
  // axi4-lite slave and transfer control
  // ------------------------------------------------------------
  always_comb begin
    awHeld_d  = awHeld_q;
    wHeld_d   = wHeld_q;
    awAddr_d  = awAddr_q;
    wData_d   = wData_q;
    wStrb_d   = wStrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    rxEn_d    = rxEn_q;
    txEn_d    = txEn_q;
    if (awvalid && awready_q) begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    if (doWrite) begin
      bvalid_d = 1'b1;
      bresp_d  = oldErr ? `PDMA_RESP_SLVERR : `PDMA_RESP_OKAY;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
    end
    if (ctrlWrite) begin
      if (wMerged[`PDMA_BIT_RX_DIS]) rxEn_d = 1'b0;
      else if (wMerged[`PDMA_BIT_RX_EN]) rxEn_d = 1'b1;
      if (wMerged[`PDMA_BIT_TX_DIS]) txEn_d = 1'b0;
      else if (wMerged[`PDMA_BIT_TX_EN]) txEn_d = 1'b1;
    end
    if (arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rdata_d   = rdRes[31:0];
      rresp_d   = rdRes[32] ? `PDMA_RESP_SLVERR : `PDMA_RESP_OKAY;
    end
    if (rvalid_q && rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    awready_d = !awHeld_d;
    wready_d  = !wHeld_d;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      awAddr_q  <= '0;
      wData_q   <= 32'h0;
      wStrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `PDMA_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `PDMA_RESP_OKAY;
      rdata_q   <= 32'h0;
      rxEn_q    <= 1'b0;
      txEn_q    <= 1'b0;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      awHeld_q  <= awHeld_d;
      wHeld_q   <= wHeld_d;
      awAddr_q  <= awAddr_d;
      wData_q   <= wData_d;
      wStrb_q   <= wStrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      rxEn_q    <= rxEn_d;
      txEn_q    <= txEn_d;
    end
  end

  // ------------------------------------------------------------
  // channels, arbiter and memory access
  // ------------------------------------------------------------
  pdma_mem_state_type memState_q, memState_d;
  logic               grantRx, grantTx, memIsRx_q, memIsRx_d;
  logic               memReq_q, memReq_d, memWe_q, memWe_d;
  logic               rxTake_q, rxTake_d, txLoad_q, txLoad_d;
  logic [31:0]        memAddr_q, memAddr_d, memWdata_q, memWdata_d, txData_q, txData_d;
  pdma_size_type      memSize_q, memSize_d;

  pdma_chan u_rxChan (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .trigger  (rxReady),
    .xferSize (xferSize),
    .ch       (rxIf.chan)
  );

  pdma_chan u_txChan (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .trigger  (txReady),
    .xferSize (xferSize),
    .ch       (txIf.chan)
  );

  pdma_arb u_arb (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .reqRx   (rxIf.req),
    .reqTx   (txIf.req),
    .busy    (memState_q != MEM_IDLE),
    .grantRx (grantRx),
    .grantTx (grantTx)
  );

  assign rxIf.done = (memState_q == MEM_DONE) && memIsRx_q;
  assign txIf.done = (memState_q == MEM_DONE) && !memIsRx_q;

  always_comb begin
    memState_d = memState_q;
    memIsRx_d  = memIsRx_q;
    memReq_d   = memReq_q;
    memWe_d    = memWe_q;
    memAddr_d  = memAddr_q;
    memWdata_d = memWdata_q;
    memSize_d  = memSize_q;
    txData_d   = txData_q;
    rxTake_d   = 1'b0;
    txLoad_d   = 1'b0;
    case (memState_q)
      MEM_IDLE: if (grantRx || grantTx) begin
        memState_d = MEM_BUS;
        memIsRx_d  = grantRx;
        memReq_d   = 1'b1;
        memWe_d    = grantRx;
        memAddr_d  = grantRx ? rxIf.curPtr : txIf.curPtr;
        memWdata_d = rxData;
        memSize_d  = xferSize;
      end
      MEM_BUS: if (memAck) begin
        memState_d = MEM_DONE;
        memReq_d   = 1'b0;
        memWe_d    = 1'b0;
        rxTake_d   = memIsRx_q;
        txLoad_d   = !memIsRx_q;
        if (!memIsRx_q) txData_d = memRdata;
      end
      MEM_DONE: memState_d = MEM_IDLE;
      default:  memState_d = MEM_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      memState_q <= MEM_IDLE;
      memIsRx_q  <= 1'b0;
      memReq_q   <= 1'b0;
      memWe_q    <= 1'b0;
      memAddr_q  <= `PDMA_PTR_RST;
      memWdata_q <= 32'h0;
      memSize_q  <= PDMA_SZ_BYTE;
      txData_q   <= 32'h0;
      rxTake_q   <= 1'b0;
      txLoad_q   <= 1'b0;
    end else begin
      memState_q <= memState_d;
      memIsRx_q  <= memIsRx_d;
      memReq_q   <= memReq_d;
      memWe_q    <= memWe_d;
      memAddr_q  <= memAddr_d;
      memWdata_q <= memWdata_d;
      memSize_q  <= memSize_d;
      txData_q   <= txData_d;
      rxTake_q   <= rxTake_d;
      txLoad_q   <= txLoad_d;
    end
  end

  assign awready            = awready_q;
  assign wready             = wready_q;
  assign bvalid             = bvalid_q;
  assign bresp              = bresp_q;
  assign arready            = arready_q;
  assign rvalid             = rvalid_q;
  assign rresp              = rresp_q;
  assign rdata              = rdata_q;
  assign memReq             = memReq_q;
  assign memWe              = memWe_q;
  assign memAddr            = memAddr_q;
  assign memWdata           = memWdata_q;
  assign memSize            = memSize_q;
  assign txData             = txData_q;
  assign rxTake             = rxTake_q;
  assign txLoad             = txLoad_q;
  assign rxBufferEnd        = rxIf.endFlag;
  assign rxBothBuffersFull  = rxIf.bothFlag;
  assign txBufferEnd        = txIf.endFlag;
  assign txBothBuffersEmpty = txIf.bothFlag;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [31:0] stepRef;
  logic        rxWr, txWr, arHit;
  assign stepRef = (xferSize == PDMA_SZ_WORD) ? `PDMA_STEP_WORD :
                   (xferSize == PDMA_SZ_HALF) ? `PDMA_STEP_HALF : `PDMA_STEP_BYTE;
  assign rxWr    = rxIf.wrPtr || rxIf.wrCnt || rxIf.wrNptr || rxIf.wrNcnt;
  assign txWr    = txIf.wrPtr || txIf.wrCnt || txIf.wrNptr || txIf.wrNcnt;
  assign arHit   = arvalid && arready_q;

  property p_rx_en;
    @(posedge sys_clk) disable iff (!rstn)
    ctrlWrite && wMerged[`PDMA_BIT_RX_EN] && !wMerged[`PDMA_BIT_RX_DIS] |=> rxEn_q;
  endproperty
  a_rx_en: assert property (p_rx_en) else $error("receive enable lost");
  property p_rx_dis;
    @(posedge sys_clk) disable iff (!rstn)
    ctrlWrite && wMerged[`PDMA_BIT_RX_DIS] && !rxIf.req && !rxReady |=> !rxEn_q ##1 !rxIf.req;
  endproperty
  a_rx_dis: assert property (p_rx_dis) else $error("receive disable lost");
  property p_tx_en;
    @(posedge sys_clk) disable iff (!rstn)
    ctrlWrite && wMerged[`PDMA_BIT_TX_EN] && !wMerged[`PDMA_BIT_TX_DIS] |=> txEn_q;
  endproperty
  a_tx_en: assert property (p_tx_en) else $error("transmit enable lost");
  property p_tx_dis;
    @(posedge sys_clk) disable iff (!rstn)
    ctrlWrite && wMerged[`PDMA_BIT_TX_DIS] |=> !txEn_q;
  endproperty
  a_tx_dis: assert property (p_tx_dis) else $error("transmit disable lost");
  property p_stat;
    @(posedge sys_clk) disable iff (!rstn)
    arHit && araddr == `PDMA_OFS_STAT |=> rdata_q[`PDMA_BIT_RX_EN] == $past(rxEn_q)
      && rdata_q[`PDMA_BIT_TX_EN] == $past(txEn_q) && rdata_q[7:1] == 7'h0 && rdata_q[31:9] == 23'h0;
  endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_rx_cnt_rd;
    @(posedge sys_clk) disable iff (!rstn)
    arHit && araddr == `PDMA_OFS_RX_CNT |=> rdata_q == {16'h0, $past(rxIf.curCnt)};
  endproperty
  a_rx_cnt_rd: assert property (p_rx_cnt_rd) else $error("count read wrong");
  property p_tx_stop;
    @(posedge sys_clk) disable iff (!rstn)
    !txIf.req && txIf.curCnt == 16'h0 |=> !txIf.req;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("transmit ran at zero");
  property p_step;
    @(posedge sys_clk) disable iff (!rstn)
    rxIf.done && !rxWr && rxIf.curCnt > `PDMA_CNT_ONE
      |=> rxIf.curPtr == $past(rxIf.curPtr) + $past(stepRef) && rxIf.curCnt == $past(rxIf.curCnt) - 16'h1;
  endproperty
  a_step: assert property (p_step) else $error("pointer step wrong");
  property p_chain;
    @(posedge sys_clk) disable iff (!rstn)
    !txIf.done && !txWr && txIf.curCnt == 16'h0 && txIf.nextCnt != 16'h0
      |=> txIf.curPtr == $past(txIf.nextPtr) && txIf.curCnt == $past(txIf.nextCnt) && txIf.nextCnt == 16'h0;
  endproperty
  a_chain: assert property (p_chain) else $error("buffer chain failed");
  property p_end;
    @(posedge sys_clk) disable iff (!rstn)
    rxIf.done && rxIf.curCnt == `PDMA_CNT_ONE |=> rxBufferEnd;
  endproperty
  a_end: assert property (p_end) else $error("end flag missing");
  property p_end_clr;
    @(posedge sys_clk) disable iff (!rstn)
    (rxIf.wrCnt || rxIf.wrNcnt) && !rxIf.done |=> !rxBufferEnd;
  endproperty
  a_end_clr: assert property (p_end_clr) else $error("end flag not cleared");
endmodule

// File: verification/pdma_partner.sv
`timescale 1ns/10ps
// ------------------------------
// memory side model
// ------------------------------
module pdma_partner (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  lat,
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  output logic             memAck,
  output logic [31:0]      memRdata
);
  logic [3:0] waitQ;
  // read data is inverted address; between acks it toggles every cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      waitQ <= 4'h0;
      memAck <= 1'b0;
      memRdata <= 32'h0;
    end else if (memReq && !memAck && waitQ == lat) begin
      memAck <= 1'b1;
      memRdata <= ~memAddr;
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      waitQ <= (memReq && !memAck) ? waitQ + 4'h1 : 4'h0;
    end
  end
endmodule

// File: verification/pdma_top_bench.sv
`timescale 1ns/10ps
module pdma_top_bench;
  import pdma_pkg::*;
  logic          sys_clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready, rxReady, rxTake, txReady, txLoad;
  logic          memReq, memWe, memAck, rxBufferEnd, rxBothBuffersFull, txBufferEnd, txBothBuffersEmpty;
  logic [11:0]   awaddr, araddr;
  logic [31:0]   wdata, rdata, rxData, txData, memAddr, memWdata, memRdata, rd_d, mA, mD;
  logic [3:0]    wstrb, lat;
  logic [2:0]    mWS;
  logic [1:0]    bresp, rresp, rd_r, wr_r;
  pdma_size_type xferSize, memSize;
  int            failures, total_checks;
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  pdma_top dut_u (.sys_clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .xferSize, .rxReady,
    .rxData, .rxTake, .txReady, .txData, .txLoad, .memReq, .memWe, .memAddr, .memSize, .memWdata, .memRdata,
    .memAck, .rxBufferEnd, .rxBothBuffersFull, .txBufferEnd, .txBothBuffersEmpty);
  pdma_partner mem_u (.sys_clk, .rstn, .lat, .memReq, .memAddr, .memAck, .memRdata);
  // ------------------------------
  // bus and compare tasks
  // ------------------------------
  task test_done;
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic ha, hw, hb;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge sys_clk); ha = awvalid && awready; hw = wvalid && wready; hb = bvalid; wr_r = bresp;
      @(posedge sys_clk); if (ha) awvalid <= 1'b0; if (hw) wvalid <= 1'b0;
      if (hb) break;
    end
    if (n == 40) begin failures++; test_done(); end
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    logic ha, hr;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge sys_clk); ha = arvalid && arready; hr = rvalid; rd_d = rdata; rd_r = rresp;
      @(posedge sys_clk); if (ha) arvalid <= 1'b0;
      if (hr) break;
    end
    if (n == 40) begin failures++; test_done(); end
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_d, exp);
  endtask
  task automatic waitp(input bit tx);
    int n;
    for (n = 0; n < 60; n++) begin
      @(negedge sys_clk);
      if (memReq) begin mA = memAddr; mD = memWdata; mWS = {memWe, memSize}; end
      if (tx ? txLoad : rxTake) break;
    end
    if (n == 60) begin failures++; test_done(); end
    @(posedge sys_clk); rxReady <= 1'b0; txReady <= 1'b0;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task regs;
    rd(12'h200); chk({30'h0, rd_r}, 32'h2);
    wr(12'h200, 32'h0); chk({30'h0, wr_r}, 32'h2);
    rdchk(12'h124, 32'h0);
    chk({31'h0, rxBothBuffersFull}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      wr(12'h100 + 12'(4 * i), 32'hC3A50001 + 32'(i));
      chk({30'h0, wr_r}, 32'h0);
      rdchk(12'h100 + 12'(4 * i), i[0] ? 32'h1 + 32'(i) : 32'hC3A50001 + 32'(i));
    end
  endtask
  task ctrl;
    logic [31:0] cw[6], ex[6];
    cw = '{32'h1, 32'h3, 32'h101, 32'h0, 32'h202, 32'h100};
    ex = '{32'h1, 32'h0, 32'h101, 32'h101, 32'h0, 32'h100};
    for (int i = 0; i < 6; i++) begin
      wr(12'h120, cw[i]);
      rdchk(12'h124, ex[i]);
    end
  endtask
  task rxChain;
    wr(12'h100, 32'h1000); wr(12'h104, 32'h1); wr(12'h110, 32'h2000); wr(12'h114, 32'h2);
    wr(12'h120, 32'h1); lat <= 4'h3; rxReady <= 1'b1;
    waitp(1'b0);
    chk(mA, 32'h1000);
    chk(mD, 32'h5A);
    chk(32'(mWS), 32'h6);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, rxBufferEnd}, 32'h1);
    rdchk(12'h100, 32'h2000);
    rdchk(12'h104, 32'h2);
    rdchk(12'h114, 32'h0);
    wr(12'h114, 32'h0);
    chk({31'h0, rxBufferEnd}, 32'h0);
    rxReady <= 1'b1;
    waitp(1'b0);
    chk(mA, 32'h2000);
    rdchk(12'h100, 32'h2004);
    rdchk(12'h104, 32'h1);
  endtask
  task txStep;
    int seen;
    wr(12'h108, 32'h3000); wr(12'h10C, 32'h2); xferSize <= PDMA_SZ_HALF; lat <= 4'h0; txReady <= 1'b1;
    waitp(1'b1);
    chk(txData, 32'hFFFFCFFF);
    chk(mA, 32'h3000);
    chk(32'(mWS), 32'h1);
    repeat (2) @(posedge sys_clk);
    rdchk(12'h108, 32'h3002);
    rdchk(12'h10C, 32'h1);
    chk({31'h0, txBufferEnd}, 32'h0);
    wr(12'h11C, 32'h0); wr(12'h10C, 32'h0); txReady <= 1'b1; seen = 0;
    repeat (10) begin @(negedge sys_clk); if (memReq !== 1'b0) seen++; end
    chk(32'(seen), 32'h0);
    chk({31'h0, txBothBuffersEmpty}, 32'h1);
    @(posedge sys_clk); txReady <= 1'b0;
    wr(12'h118, 32'h4000); wr(12'h11C, 32'h1); txReady <= 1'b1;
    waitp(1'b1);
    chk(txData, 32'hFFFFBFFF);
    rdchk(12'h108, 32'h4002);
    rdchk(12'h11C, 32'h0);
    chk({31'h0, txBufferEnd}, 32'h1);
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, rxReady, txReady} = '0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hF; lat = 4'h0; rxData = 32'h5A;
    xferSize = PDMA_SZ_WORD; rstn = 1'b0; failures = 0; total_checks = 0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    regs(); ctrl(); rxChain(); txStep();
    test_done();
  end
endmodule
